// *** logic/mie_pkg.sv ***
/*
  Package for the instruction execute block: operation codes, request and
  flag carriers, register offsets, widths and reset values.
  Assumes a single core clock and the core reset.
*/
package mie_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned PC_W    = 11;
  localparam int unsigned MADDR_W = 8;
  localparam int unsigned RADDR_W = 4;

  // ==========================================================
  // Register offsets on the plain register port
  localparam logic [RADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [RADDR_W-1:0] REG_INTERRUPT_CONTROL_REGISTER   = 4'h1;

  // ==========================================================
  // Reset values
  localparam logic [7:0]      RST_ACC  = 8'h00;
  localparam logic [PC_W-1:0] RST_PC   = 11'h000;
  localparam logic [5:0]      RST_FLG  = 6'h00;
  localparam logic            RST_GIE  = 1'b0;
  localparam logic [7:0]      RD_ZERO  = 8'h00;

  // ==========================================================
  // Operation codes
  typedef enum logic [4:0] {
    OP_POWERDOWN      = 5'h00,
    OP_INCREMENT      = 5'h01,
    OP_INCREMENT_ACC  = 5'h02,
    OP_DIRECT_JUMP    = 5'h03,
    OP_MOVE_ACC_MEM   = 5'h04,
    OP_MOVE_ACC_IMM   = 5'h05,
    OP_MOVE_MEM_ACC   = 5'h06,
    OP_NO_OPERATION   = 5'h07,
    OP_OR_ACC_MEM     = 5'h08,
    OP_OR_ACC_IMM     = 5'h09,
    OP_OR_TO_MEMORY   = 5'h0a,
    OP_SUB_RETURN     = 5'h0b,
    OP_RETURN_IMM     = 5'h0c,
    OP_INT_RETURN     = 5'h0d,
    OP_ROT_LEFT       = 5'h0e,
    OP_ROT_LEFT_ACC   = 5'h0f,
    OP_ROT_LEFT_C     = 5'h10,
    OP_ROT_LEFT_C_ACC = 5'h11,
    OP_ROT_RIGHT      = 5'h12,
    OP_ROT_RIGHT_ACC  = 5'h13,
    OP_ROT_RIGHT_C    = 5'h14,
    OP_ROT_RIGHT_C_ACC = 5'h15
  } mie_op_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    mie_op_t            op;
    logic [MADDR_W-1:0] maddr;
    logic [7:0]         imm;
    logic [PC_W-1:0]    jaddr;
  } mie_req_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } mie_flags_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_RET2 = 2'b01,
    ST_HALT = 2'b10
  } mie_state_t;

endpackage

// *** logic/mie_exec.sv ***
/*
  Execute stage for part of an 8-bit instruction set: power-down, increment,
  jump, moves, no-operation, OR, returns and rotates.
  Assumes the operand byte of the addressed data memory location arrives with
  the request, the return stack top is presented by the stack logic, and all
  inputs are on mclk.
*/
// Our own choices: strobed register access and the register addresses.
//
// How it works
// [RULE1] Power-down keeps data, clears watchdog, sets powerdown, clears timeout, PC plus one.
// [RULE2] Increment adds one to the memory byte, writes it back, updates zero only.
// [RULE3] Increment-to-acc puts byte plus one in acc, memory kept, zero only.
// [RULE4] Direct jump loads PC bits 0 to 10 from the address field, no flags.
// [RULE5] Moves copy memory to acc, acc to memory, or immediate to acc; no flags.
// [RULE6] No-operation only advances the PC by one.
// [RULE7] OR of acc with memory or immediate goes to acc, zero flag only.
// [RULE8] OR-to-memory writes acc OR byte back to memory, zero flag only.
// [RULE9] Subroutine return reloads PC from stack, takes two cycles, no flags.
// [RULE10] Return-with-value reloads PC from stack and loads immediate into acc.
// [RULE11] Interrupt return reloads PC from stack and sets global interrupt enable.
// [RULE12] Rotate left in place wraps bit 7 into bit 0, no flags.
// [RULE13] Rotate left to acc wraps bit 7 to bit 0, memory and flags kept.
// [RULE14] Rotate left through carry in place: old carry to bit 0, bit 7 to carry.
// [RULE15] Rotate left through carry to acc: old carry bit 0, bit 7 to carry.
// [RULE16] Rotate right in place wraps bit 0 into bit 7, no flags.
// [RULE17] Rotate right to acc wraps bit 0 to bit 7, memory and flags kept.
// [RULE18] Rotate right through carry in place: old carry bit 7, bit 0 to carry.
// [RULE19] Power-down stops execution and turns the system clock off.
// [RULE20] Instructions not loading the PC advance it by one.
`timescale 1ns/1ps
module mie_exec (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  input  wire logic                         exec_valid,
  input  wire mie_pkg::mie_req_t            exec_req,
  input  wire logic [7:0]                   mem_rdata,
  input  wire logic [mie_pkg::PC_W-1:0]     stack_top,
  input  wire logic                         wake_req,
  input  wire logic [mie_pkg::RADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata,
  output logic                              exec_ready,
  output logic [mie_pkg::PC_W-1:0]          pc,
  output logic [7:0]                        accumulator,
  output mie_pkg::mie_flags_t               flags,
  output logic                              global_interrupt_enable,
  output logic                              mem_we,
  output logic [mie_pkg::MADDR_W-1:0]       mem_addr,
  output logic [7:0]                        mem_wdata,
  output logic                              stack_pop,
  output logic                              watchdog_clear,
  output logic                              sys_clk_off
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rot_left(input logic [7:0] b, input logic in0);
    rot_left = {b[6:0], in0};
  endfunction

  function automatic logic [7:0] rot_right(input logic [7:0] b, input logic in7);
    rot_right = {in7, b[7:1]};
  endfunction

  // ==========================================================
  // State
  mie_pkg::mie_state_t          st_r;
  mie_pkg::mie_state_t          st_nxt;
  logic                         ready_r;
  logic [mie_pkg::PC_W-1:0]     pc_r;
  logic [mie_pkg::PC_W-1:0]     pc_nxt;
  logic [7:0]                   acc_r;
  logic [7:0]                   acc_nxt;
  mie_pkg::mie_flags_t          flg_r;
  mie_pkg::mie_flags_t          flg_nxt;
  logic                         gie_r;
  logic                         gie_nxt;
  logic                         mwe_r;
  logic                         mwe_nxt;
  logic [mie_pkg::MADDR_W-1:0]  maddr_r;
  logic [mie_pkg::MADDR_W-1:0]  maddr_nxt;
  logic [7:0]                   mwd_r;
  logic [7:0]                   mwd_nxt;
  logic                         pop_r;
  logic                         pop_nxt;
  logic                         wclr_r;
  logic                         wclr_nxt;
  logic                         off_r;
  logic                         off_nxt;
  logic [7:0]                   rdata_r;

  // ==========================================================
  // Decode
  wire                          take      = exec_valid && ready_r;
  wire [7:0]                    opnd      = mem_rdata;
  wire [7:0]                    inc_res   = opnd + 8'h01;
  wire [7:0]                    or_res    = acc_r | opnd;
  wire [7:0]                    or_imm    = acc_r | exec_req.imm;
  wire [mie_pkg::PC_W-1:0]      pc_inc    = pc_r + 11'h001;
  wire                          wr_stat   = reg_wr && (reg_addr == mie_pkg::REG_STATUS);
  wire                          wr_interrupt_control_register   = reg_wr && (reg_addr == mie_pkg::REG_INTERRUPT_CONTROL_REGISTER);
  wire [7:0]                    rd_sel    =
    (reg_addr == mie_pkg::REG_STATUS) ? {2'h0, flg_r} :
    (reg_addr == mie_pkg::REG_INTERRUPT_CONTROL_REGISTER)   ? {7'h00, gie_r} : mie_pkg::RD_ZERO;
  wire [7:0]                    rdata_nxt = reg_rd ? rd_sel : mie_pkg::RD_ZERO;

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt    = st_r;
    pc_nxt    = pc_r;
    acc_nxt   = acc_r;
    flg_nxt   = flg_r;
    gie_nxt   = gie_r;
    mwe_nxt   = 1'b0;
    maddr_nxt = maddr_r;
    mwd_nxt   = mwd_r;
    pop_nxt   = 1'b0;
    wclr_nxt  = 1'b0;
    off_nxt   = off_r;
    // Software writes first; an instruction in the same cycle wins
    if (wr_stat)
    begin
      flg_nxt = mie_pkg::mie_flags_t'(reg_wdata[5:0]);
    end
    if (wr_interrupt_control_register)
    begin
      gie_nxt = reg_wdata[0];
    end
    unique case (st_r)
      mie_pkg::ST_RUN:
      begin
        if (take)
        begin
          pc_nxt    = pc_inc; // RULE20
          maddr_nxt = exec_req.maddr;
          unique case (exec_req.op)
            mie_pkg::OP_POWERDOWN:
            begin
              flg_nxt.powerdown_flag = 1'b1; // RULE1
              flg_nxt.timeout_flag   = 1'b0; // RULE1
              wclr_nxt               = 1'b1; // RULE1
              off_nxt                = 1'b1; // RULE19
              st_nxt                 = mie_pkg::ST_HALT; // RULE19
            end
            mie_pkg::OP_INCREMENT:
            begin
              mwe_nxt           = 1'b1; // RULE2
              mwd_nxt           = inc_res; // RULE2
              flg_nxt.zero_flag = (inc_res == 8'h00); // RULE2
            end
            mie_pkg::OP_INCREMENT_ACC:
            begin
              acc_nxt           = inc_res; // RULE3
              flg_nxt.zero_flag = (inc_res == 8'h00); // RULE3
            end
            mie_pkg::OP_DIRECT_JUMP:
            begin
              pc_nxt = exec_req.jaddr; // RULE4
            end
            mie_pkg::OP_MOVE_ACC_MEM:
            begin
              acc_nxt = opnd; // RULE5
            end
            mie_pkg::OP_MOVE_ACC_IMM:
            begin
              acc_nxt = exec_req.imm; // RULE5
            end
            mie_pkg::OP_MOVE_MEM_ACC:
            begin
              mwe_nxt = 1'b1; // RULE5
              mwd_nxt = acc_r; // RULE5
            end
            mie_pkg::OP_NO_OPERATION:
            begin
              pc_nxt = pc_inc; // RULE6
            end
            mie_pkg::OP_OR_ACC_MEM:
            begin
              acc_nxt           = or_res; // RULE7
              flg_nxt.zero_flag = (or_res == 8'h00); // RULE7
            end
            mie_pkg::OP_OR_ACC_IMM:
            begin
              acc_nxt           = or_imm; // RULE7
              flg_nxt.zero_flag = (or_imm == 8'h00); // RULE7
            end
            mie_pkg::OP_OR_TO_MEMORY:
            begin
              mwe_nxt           = 1'b1; // RULE8
              mwd_nxt           = or_res; // RULE8
              flg_nxt.zero_flag = (or_res == 8'h00); // RULE8
            end
            mie_pkg::OP_SUB_RETURN:
            begin
              pc_nxt  = stack_top; // RULE9
              pop_nxt = 1'b1;
              st_nxt  = mie_pkg::ST_RET2; // RULE9
            end
            mie_pkg::OP_RETURN_IMM:
            begin
              pc_nxt  = stack_top; // RULE10
              acc_nxt = exec_req.imm; // RULE10
              pop_nxt = 1'b1;
              st_nxt  = mie_pkg::ST_RET2;
            end
            mie_pkg::OP_INT_RETURN:
            begin
              pc_nxt  = stack_top; // RULE11
              gie_nxt = 1'b1; // RULE11
              pop_nxt = 1'b1;
              st_nxt  = mie_pkg::ST_RET2;
            end
            mie_pkg::OP_ROT_LEFT:
            begin
              mwe_nxt = 1'b1; // RULE12
              mwd_nxt = rot_left(opnd, opnd[7]); // RULE12
            end
            mie_pkg::OP_ROT_LEFT_ACC:
            begin
              acc_nxt = rot_left(opnd, opnd[7]); // RULE13
            end
            mie_pkg::OP_ROT_LEFT_C:
            begin
              mwe_nxt            = 1'b1; // RULE14
              mwd_nxt            = rot_left(opnd, flg_r.carry_flag); // RULE14
              flg_nxt.carry_flag = opnd[7]; // RULE14
            end
            mie_pkg::OP_ROT_LEFT_C_ACC:
            begin
              acc_nxt            = rot_left(opnd, flg_r.carry_flag); // RULE15
              flg_nxt.carry_flag = opnd[7]; // RULE15
            end
            mie_pkg::OP_ROT_RIGHT:
            begin
              mwe_nxt = 1'b1; // RULE16
              mwd_nxt = rot_right(opnd, opnd[0]); // RULE16
            end
            mie_pkg::OP_ROT_RIGHT_ACC:
            begin
              acc_nxt = rot_right(opnd, opnd[0]); // RULE17
            end
            mie_pkg::OP_ROT_RIGHT_C:
            begin
              mwe_nxt            = 1'b1; // RULE18
              mwd_nxt            = rot_right(opnd, flg_r.carry_flag); // RULE18
              flg_nxt.carry_flag = opnd[0]; // RULE18
            end
            mie_pkg::OP_ROT_RIGHT_C_ACC:
            begin
              acc_nxt            = rot_right(opnd, flg_r.carry_flag);
              flg_nxt.carry_flag = opnd[0];
            end
            default:
            begin
              pc_nxt = pc_inc;
            end
          endcase
        end
      end
      mie_pkg::ST_RET2:
      begin
        st_nxt = mie_pkg::ST_RUN; // RULE9
      end
      mie_pkg::ST_HALT:
      begin
        if (wake_req)
        begin
          st_nxt  = mie_pkg::ST_RUN;
          off_nxt = 1'b0;
        end
      end
      default:
      begin
        st_nxt = mie_pkg::ST_RUN;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r    <= mie_pkg::ST_RUN;
      ready_r <= 1'b1;
      pc_r    <= mie_pkg::RST_PC;
      acc_r   <= mie_pkg::RST_ACC;
      flg_r   <= mie_pkg::mie_flags_t'(mie_pkg::RST_FLG);
      gie_r   <= mie_pkg::RST_GIE;
      mwe_r   <= 1'b0;
      maddr_r <= '0;
      mwd_r   <= mie_pkg::RST_ACC;
      pop_r   <= 1'b0;
      wclr_r  <= 1'b0;
      off_r   <= 1'b0;
      rdata_r <= mie_pkg::RD_ZERO;
    end
    else
    begin
      st_r    <= st_nxt;
      ready_r <= (st_nxt == mie_pkg::ST_RUN); // RULE19
      pc_r    <= pc_nxt;
      acc_r   <= acc_nxt;
      flg_r   <= flg_nxt;
      gie_r   <= gie_nxt;
      mwe_r   <= mwe_nxt;
      maddr_r <= maddr_nxt;
      mwd_r   <= mwd_nxt;
      pop_r   <= pop_nxt;
      wclr_r  <= wclr_nxt;
      off_r   <= off_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata               = rdata_r;
  assign exec_ready              = ready_r;
  assign pc                      = pc_r;
  assign accumulator             = acc_r;
  assign flags                   = flg_r;
  assign global_interrupt_enable = gie_r;
  assign mem_we                  = mwe_r;
  assign mem_addr                = maddr_r;
  assign mem_wdata               = mwd_r;
  assign stack_pop               = pop_r;
  assign watchdog_clear          = wclr_r;
  assign sys_clk_off             = off_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  wire quiet = !reg_wr;

  sequence s_take(mie_pkg::mie_op_t o);
    take && exec_req.op == o && quiet;
  endsequence

  sequence s_ret_tail;
    !exec_ready ##1 exec_ready;
  endsequence

  property p_halt;
    s_take(mie_pkg::OP_POWERDOWN) |=> flags.powerdown_flag && !flags.timeout_flag
      && watchdog_clear && !mem_we && pc == $past(pc_inc) && sys_clk_off;
  endproperty
  a_halt: assert property (p_halt) else $error("power-down entry wrong"); // RULE1

  property p_halt_stop;
    s_take(mie_pkg::OP_POWERDOWN) ##1 !wake_req |=> !exec_ready && sys_clk_off;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop"); // RULE19

  property p_inc;
    s_take(mie_pkg::OP_INCREMENT) |=> mem_we && mem_wdata == $past(inc_res)
      && flags.zero_flag == (mem_wdata == 8'h00) && flags.carry_flag == $past(flg_r.carry_flag);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong"); // RULE2

  property p_increment_to_acc_op;
    s_take(mie_pkg::OP_INCREMENT_ACC) |=> !mem_we && accumulator == $past(inc_res)
      && flags.zero_flag == (accumulator == 8'h00);
  endproperty
  a_increment_to_acc_op: assert property (p_increment_to_acc_op) else $error("increment to acc wrong"); // RULE3

  property p_jump;
    s_take(mie_pkg::OP_DIRECT_JUMP) |=> pc == $past(exec_req.jaddr) && $stable(flags);
  endproperty
  a_jump: assert property (p_jump) else $error("jump wrong"); // RULE4

  property p_move_imm;
    s_take(mie_pkg::OP_MOVE_ACC_IMM) |=> accumulator == $past(exec_req.imm) && $stable(flags);
  endproperty
  a_move_imm: assert property (p_move_imm) else $error("move immediate wrong"); // RULE5

  property p_nop;
    s_take(mie_pkg::OP_NO_OPERATION) |=> pc == $past(pc_inc) && $stable(accumulator)
      && $stable(flags) && !mem_we;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state"); // RULE6

  property p_or;
    s_take(mie_pkg::OP_OR_ACC_MEM) |=> accumulator == ($past(acc_r) | $past(mem_rdata));
  endproperty
  a_or: assert property (p_or) else $error("or to acc wrong"); // RULE7

  property p_orm;
    s_take(mie_pkg::OP_OR_TO_MEMORY) |=> mem_we && mem_wdata == $past(or_res) && $stable(accumulator);
  endproperty
  a_orm: assert property (p_orm) else $error("or to memory wrong"); // RULE8

  property p_ret;
    s_take(mie_pkg::OP_SUB_RETURN) |=> pc == $past(stack_top) && stack_pop
      && $stable(flags) ##0 s_ret_tail;
  endproperty
  a_ret: assert property (p_ret) else $error("return timing wrong"); // RULE9

  property p_interrupt_return_op;
    s_take(mie_pkg::OP_INT_RETURN) |=> global_interrupt_enable && pc == $past(stack_top);
  endproperty
  a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("interrupt return wrong"); // RULE11

  property p_rlc;
    s_take(mie_pkg::OP_ROT_LEFT_C) |=> flags.carry_flag == $past(mem_rdata[7])
      && mem_wdata[0] == $past(flg_r.carry_flag);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left carry wrong"); // RULE14

  property p_rr;
    s_take(mie_pkg::OP_ROT_RIGHT) |=> mem_we && mem_wdata[7] == $past(mem_rdata[0])
      && $stable(flags);
  endproperty
  a_rr: assert property (p_rr) else $error("rotate right wrong"); // RULE16

  property p_rrc;
    s_take(mie_pkg::OP_ROT_RIGHT_C) |=> flags.carry_flag == $past(mem_rdata[0])
      && mem_wdata[7] == $past(flg_r.carry_flag);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right carry wrong"); // RULE18

endmodule

// *** sim/mie_mem_model.sv ***
/*
  Data memory and return stack standing beside the execute block.
  Assumes requests and write pulses are on mclk; read data is combinational.
*/
`timescale 1ns/1ps
module mie_mem_model (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [7:0]   maddr,
  input  wire logic         mem_we,
  input  wire logic [7:0]   mem_addr,
  input  wire logic [7:0]   mem_wdata,
  output logic [7:0]        mem_rdata,
  input  wire logic         stack_pop,
  output logic [10:0]       stack_top
);
  // ==========================================================
  // Storage
  logic [7:0]  mem [256];
  logic [10:0] stk_r;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 59) ^ 8'h5a;
  end

  // Pending write is forwarded so back-to-back ops see it
  assign mem_rdata = (mem_we && mem_addr == maddr) ? mem_wdata : mem[maddr];
  assign stack_top = stk_r;

  always @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  // Each pop exposes the next entry
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stk_r <= 11'h5a3;
    else if (stack_pop)
      stk_r <= stk_r + 11'h1d7;
  end
endmodule

// *** sim/tb.sv ***
/*
  Self-checking bench for the execute block: random and directed instructions,
  register port, halt and wake.
  Assumes the memory and stack model sit on the far side.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals
  logic                 mclk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 exec_valid = 1'b0;
  mie_pkg::mie_req_t    exec_req = '0;
  logic [7:0]           mem_rdata;
  logic [10:0]          stack_top;
  logic                 wake_req = 1'b0;
  logic [3:0]           reg_addr = 4'h0;
  logic [7:0]           reg_wdata = 8'h00;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [7:0]           reg_rdata;
  logic                 exec_ready;
  logic [10:0]          pc;
  logic [7:0]           accumulator;
  mie_pkg::mie_flags_t  flags;
  logic                 global_interrupt_enable;
  logic                 mem_we;
  logic [7:0]           mem_addr;
  logic [7:0]           mem_wdata;
  logic                 stack_pop;
  logic                 watchdog_clear;
  logic                 sys_clk_off;
  int                   failures = 0;
  int                   tests_run = 0;
  logic [7:0]           shadow [256];
  logic [10:0]          e_pc = 11'h000;
  logic [10:0]          e_stk = 11'h5a3;
  logic [7:0]           e_acc = 8'h00;
  logic [5:0]           e_flg = 6'h00;
  logic                 e_gie = 1'b0;

  always #20 mclk = ~mclk;

  mie_exec dut (.mclk(mclk), .rstn(rstn), .exec_valid(exec_valid), .exec_req(exec_req),
    .mem_rdata(mem_rdata), .stack_top(stack_top), .wake_req(wake_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .exec_ready(exec_ready), .pc(pc), .accumulator(accumulator), .flags(flags),
    .global_interrupt_enable(global_interrupt_enable), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .stack_pop(stack_pop), .watchdog_clear(watchdog_clear),
    .sys_clk_off(sys_clk_off));

  mie_mem_model partner (.mclk(mclk), .rstn(rstn), .maddr(exec_req.maddr), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .stack_pop(stack_pop), .stack_top(stack_top));

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Instruction driver with its own expectation
  task automatic run(input mie_pkg::mie_req_t r);
    logic [7:0] m;
    logic [7:0] wd;
    logic       we;
    logic       ret;
    logic       c;
    do @(posedge mclk); while (exec_ready !== 1'b1);
    m = shadow[r.maddr];
    c = e_flg[0];
    we = 1'b0;
    wd = 8'h00;
    ret = r.op inside {mie_pkg::OP_SUB_RETURN, mie_pkg::OP_RETURN_IMM, mie_pkg::OP_INT_RETURN};
    e_pc = e_pc + 11'h001;
    case (r.op)
      mie_pkg::OP_POWERDOWN: e_flg[5:4] = 2'b01;
      mie_pkg::OP_INCREMENT: {we, wd} = {1'b1, m + 8'h01};
      mie_pkg::OP_INCREMENT_ACC: e_acc = m + 8'h01;
      mie_pkg::OP_DIRECT_JUMP: e_pc = r.jaddr;
      mie_pkg::OP_MOVE_ACC_MEM: e_acc = m;
      mie_pkg::OP_MOVE_ACC_IMM: e_acc = r.imm;
      mie_pkg::OP_MOVE_MEM_ACC: {we, wd} = {1'b1, e_acc};
      mie_pkg::OP_OR_ACC_MEM: e_acc = e_acc | m;
      mie_pkg::OP_OR_ACC_IMM: e_acc = e_acc | r.imm;
      mie_pkg::OP_OR_TO_MEMORY: {we, wd} = {1'b1, e_acc | m};
      mie_pkg::OP_RETURN_IMM: e_acc = r.imm;
      mie_pkg::OP_INT_RETURN: e_gie = 1'b1;
      mie_pkg::OP_ROT_LEFT: {we, wd} = {1'b1, m[6:0], m[7]};
      mie_pkg::OP_ROT_LEFT_ACC: e_acc = {m[6:0], m[7]};
      mie_pkg::OP_ROT_LEFT_C: {we, wd, e_flg[0]} = {1'b1, m[6:0], c, m[7]};
      mie_pkg::OP_ROT_LEFT_C_ACC: {e_acc, e_flg[0]} = {m[6:0], c, m[7]};
      mie_pkg::OP_ROT_RIGHT: {we, wd} = {1'b1, m[0], m[7:1]};
      mie_pkg::OP_ROT_RIGHT_ACC: e_acc = {m[0], m[7:1]};
      mie_pkg::OP_ROT_RIGHT_C: {we, wd, e_flg[0]} = {1'b1, c, m[7:1], m[0]};
      mie_pkg::OP_ROT_RIGHT_C_ACC: {e_acc, e_flg[0]} = {c, m[7:1], m[0]};
      default: ;
    endcase
    if (ret)
      e_pc = e_stk;
    if (r.op inside {mie_pkg::OP_INCREMENT, mie_pkg::OP_OR_TO_MEMORY})
      e_flg[2] = (wd == 8'h00);
    if (r.op inside {mie_pkg::OP_INCREMENT_ACC, mie_pkg::OP_OR_ACC_MEM, mie_pkg::OP_OR_ACC_IMM})
      e_flg[2] = (e_acc == 8'h00);
    exec_valid <= 1'b1;
    exec_req <= r;
    @(posedge mclk);
    exec_valid <= 1'b0;
    #1;
    chk(pc, e_pc);
    chk(accumulator, e_acc);
    chk(flags, e_flg);
    chk(global_interrupt_enable, e_gie);
    chk(mem_we, we);
    if (we)
      chk({mem_addr, mem_wdata}, {r.maddr, wd});
    chk(stack_pop, ret);
    chk(exec_ready, !(ret || r.op == mie_pkg::OP_POWERDOWN));
    chk({watchdog_clear, sys_clk_off}, {2{r.op == mie_pkg::OP_POWERDOWN}});
    if (we)
      shadow[r.maddr] = wd;
    if (ret)
      e_stk = e_stk + 11'h1d7;
    if (r.op == mie_pkg::OP_POWERDOWN)
    begin
      repeat (2) @(posedge mclk);
      exec_valid <= 1'b1;
      @(posedge mclk);
      #1;
      chk({exec_ready, watchdog_clear, sys_clk_off, pc}, {3'b001, e_pc});
      @(posedge mclk);
      exec_valid <= 1'b0;
      wake_req <= 1'b1;
      @(posedge mclk);
      wake_req <= 1'b0;
    end
  endtask

  // ==========================================================
  // Register port access
  task automatic rw(input logic wr, input logic [3:0] ad, input logic [7:0] d,
                    input logic [7:0] ex);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!wr)
      chk(reg_rdata, ex);
    @(posedge mclk);
    #1;
    chk(reg_rdata, 8'h00);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    mie_pkg::mie_req_t r;
    for (int i = 0; i < 256; i++)
      shadow[i] = 8'(i * 59) ^ 8'h5a;
    void'($urandom(56333));
    repeat (12) @(posedge mclk);
    chk({exec_ready, pc, accumulator, flags}, {1'b1, 25'h000_0000});
    rstn <= 1'b1;
    rw(1'b0, 4'h7, 8'h00, 8'h00);
    rw(1'b1, mie_pkg::REG_STATUS, 8'h3d, 8'h00);
    e_flg = 6'h3d;
    rw(1'b0, mie_pkg::REG_STATUS, 8'h00, 8'h3d);
    rw(1'b1, 4'h9, 8'hff, 8'h00);
    rw(1'b0, mie_pkg::REG_INTERRUPT_CONTROL_REGISTER, 8'h00, 8'h00);
    // Boundary values: wrap to zero, carry chain, back-to-back memory reuse
    run('{mie_pkg::OP_MOVE_ACC_IMM, 8'h05, 8'hff, 11'h7ff});
    run('{mie_pkg::OP_MOVE_MEM_ACC, 8'h05, 8'h00, 11'h000});
    run('{mie_pkg::OP_INCREMENT, 8'h05, 8'h00, 11'h000});
    run('{mie_pkg::OP_INCREMENT_ACC, 8'h05, 8'h00, 11'h000});
    run('{mie_pkg::OP_ROT_LEFT_C, 8'h05, 8'h00, 11'h000});
    run('{mie_pkg::OP_DIRECT_JUMP, 8'h00, 8'h00, 11'h7ff});
    run('{mie_pkg::OP_NO_OPERATION, 8'h00, 8'h00, 11'h000});
    run('{mie_pkg::OP_INT_RETURN, 8'h00, 8'h00, 11'h000});
    run('{mie_pkg::OP_SUB_RETURN, 8'h00, 8'h00, 11'h000});
    rw(1'b0, mie_pkg::REG_INTERRUPT_CONTROL_REGISTER, 8'h00, {7'h00, e_gie});
    run('{mie_pkg::OP_POWERDOWN, 8'h00, 8'h00, 11'h000});
    rw(1'b1, mie_pkg::REG_INTERRUPT_CONTROL_REGISTER, 8'h00, 8'h00);
    e_gie = 1'b0;
    for (int n = 0; n < 600; n++)
    begin
      r.op = mie_pkg::mie_op_t'(5'($urandom_range(0, 23)));
      r.maddr = 8'($urandom_range(0, 15));
      r.imm = 8'($urandom);
      r.jaddr = 11'($urandom);
      run(r);
    end
    summarize();
  end

  initial
  begin
    #1_000_000;
    failures++;
    summarize();
  end
endmodule
